// ### src/ird_distributor.sv
/*
 * Interrupt distributor state: enable, pending, active and priority per
 * interrupt, an Avalon-MM slave with waitrequest, and the forward to one CPU
 * interface. Assumes active flags and software pends come from the CPU
 * interface and software interrupt logic outside this block.
 */
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "ird_cfg.svh"

module ird_distributor
	import ird_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    clk_en,
	input  wire logic [`IRD_ADDR_W-1:0]  avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest,
	input  wire ird_vec_t                irq_lines,
	input  wire ird_vec_t                sw_pend_set,
	input  wire ird_vec_t                active_in,
	output logic                         cpu_irq_valid,
	output ird_id_t                      cpu_irq_id,
	output ird_prio_t                    cpu_irq_prio,
	output ird_vec_t                     pending_out
);
	ird_vec_t         enable_r;
	ird_vec_t         pending_r;
	ird_vec_t         active_r;
	ird_vec_t         line_event;
	logic [`IRD_NUM_IRQ*4-1:0] prio_r;
	logic             dist_en_r;
	ird_prio_t        pmask_r;
	ird_bus_state_t   bus_state_r;
	logic [31:0]      rdata_nxt;
	logic             wr_go;
	logic [31:0]      wmask;
	logic             sel_found;
	ird_id_t          sel_id;
	ird_prio_t        sel_prio;

	// bits a software write may touch; 15..0 and 28..16 of the low word never
	function automatic logic [31:0] wr_mask(input logic high);
		return high ? `IRD_HIGH_WR_MASK : `IRD_LOW_WR_MASK;
	endfunction

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// mask of present bits, used for every enable/pending view
	function automatic logic [31:0] view(input ird_vec_t v, input logic high);
		return high ? v[63:32] : (v[31:0] & `IRD_LOW_WR_MASK);
	endfunction

	ird_edge_detect u_edge
	(
		.clk         (clk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.lines       (irq_lines),
		.event_pulse (line_event)
	);

	ird_select u_sel
	(
		.cand      (pending_r & enable_r & ~active_r),
		.prio_flat (prio_r),
		.found     (sel_found),
		.best_id   (sel_id),
		.best_prio (sel_prio)
	);

	// one wait cycle: request taken in IDLE, answered in ACK
	assign wr_go = avs_write && bus_state_r == IRD_BUS_ACK;
	assign wmask = be_mask(avs_byteenable) & avs_writedata;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bus_state_r <= IRD_BUS_IDLE;
		else if (clk_en)
		begin
			unique case (bus_state_r)
				IRD_BUS_IDLE: if (avs_read || avs_write) bus_state_r <= IRD_BUS_ACK;
				IRD_BUS_ACK:  bus_state_r <= IRD_BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else if (clk_en)
			avs_waitrequest <= !(bus_state_r == IRD_BUS_IDLE && (avs_read || avs_write));
	end

	// no bypass: a read sees the state from before a same-edge write
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		unique case (avs_address)
			`IRD_OFF_CTRL:        rdata_nxt = {31'h0, dist_en_r};
			`IRD_OFF_TYPE:        rdata_nxt = {27'h0, `IRD_IMPL_LINES};
			`IRD_OFF_EN_SET_LO:   rdata_nxt = view(enable_r, 1'b0);
			`IRD_OFF_EN_SET_HI:   rdata_nxt = view(enable_r, 1'b1);
			`IRD_OFF_EN_CLR_LO:   rdata_nxt = view(enable_r, 1'b0);
			`IRD_OFF_EN_CLR_HI:   rdata_nxt = view(enable_r, 1'b1);
			`IRD_OFF_PEND_SET_LO,
			`IRD_OFF_PEND_CLR_LO: rdata_nxt = view(pending_r, 1'b0) | {16'h0, pending_r[15:0]};
			`IRD_OFF_PEND_SET_HI,
			`IRD_OFF_PEND_CLR_HI: rdata_nxt = view(pending_r, 1'b1);
			`IRD_OFF_ACT_LO:      rdata_nxt = active_r[31:0];
			`IRD_OFF_ACT_HI:      rdata_nxt = active_r[63:32];
			`IRD_OFF_PMASK:       rdata_nxt = {28'h0, pmask_r};
			`IRD_OFF_SELECT:      rdata_nxt = {23'h0, sel_found, 2'h0, sel_id};
			default:
			begin
				// priority fields in the upper nibble of each byte
				if (avs_address >= `IRD_OFF_PRIO_BASE && avs_address <= `IRD_OFF_PRIO_LAST
					&& avs_address[1:0] == 2'b00)
				begin
					for (int k = 0; k < 4; k++)
						rdata_nxt[k*8+4 +: 4] = prio_r[(32'(avs_address[5:2])*4+k)*4 +: 4];
				end
			end
		endcase
	end

	// read data captured in the request cycle, valid while waitrequest is low
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			avs_readdata <= 32'h0000_0000;
		else if (clk_en && bus_state_r == IRD_BUS_IDLE && avs_read)
			avs_readdata <= rdata_nxt;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dist_en_r <= 1'b0;
			pmask_r <= `IRD_PMASK_RESET;
		end
		else if (clk_en && wr_go)
		begin
			if (avs_address == `IRD_OFF_CTRL && avs_byteenable[0])
				dist_en_r <= avs_writedata[`IRD_CTRL_EN_BIT];
			if (avs_address == `IRD_OFF_PMASK && avs_byteenable[0])
				pmask_r <= avs_writedata[3:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			enable_r <= '0;
		else if (clk_en && wr_go)
		begin
			unique case (avs_address)
				`IRD_OFF_EN_SET_LO: enable_r[31:0] <= enable_r[31:0]
					| (wmask & wr_mask(1'b0));
				`IRD_OFF_EN_SET_HI: enable_r[63:32] <= enable_r[63:32] | wmask;
				`IRD_OFF_EN_CLR_LO: enable_r[31:0] <= enable_r[31:0]
					& ~(wmask & wr_mask(1'b0));
				`IRD_OFF_EN_CLR_HI: enable_r[63:32] <= enable_r[63:32] & ~wmask;
				default: ;
			endcase
		end
	end

	// pending: hardware and software sets win over a same-cycle clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pending_r <= '0;
		else if (clk_en)
		begin
			ird_vec_t clr;
			ird_vec_t set;
			clr = '0;
			set = line_event & {{32{1'b1}}, `IRD_LOW_WR_MASK} | sw_pend_set & 64'h0000_0000_0000_FFFF;
			if (wr_go)
			begin
				unique case (avs_address)
					`IRD_OFF_PEND_SET_LO: set[31:0] = set[31:0] | (wmask & wr_mask(1'b0));
					`IRD_OFF_PEND_SET_HI: set[63:32] = set[63:32] | wmask;
					`IRD_OFF_PEND_CLR_LO: clr[31:0] = wmask & wr_mask(1'b0);
					`IRD_OFF_PEND_CLR_HI: clr[63:32] = wmask;
					default: ;
				endcase
			end
			pending_r <= (pending_r & ~clr) | set;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			active_r <= '0;
		else if (clk_en)
			active_r <= active_in;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prio_r <= '0;
		else if (clk_en && wr_go && avs_address >= `IRD_OFF_PRIO_BASE
			&& avs_address <= `IRD_OFF_PRIO_LAST && avs_address[1:0] == 2'b00)
		begin
			for (int k = 0; k < 4; k++)
				if (avs_byteenable[k])
					prio_r[(32'(avs_address[5:2])*4+k)*4 +: 4]
						<= avs_writedata[k*8+4 +: 4];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_irq_valid <= 1'b0;
			cpu_irq_id <= '0;
			cpu_irq_prio <= 4'hF;
		end
		else if (clk_en)
		begin
			cpu_irq_valid <= dist_en_r && sel_found && sel_prio < pmask_r;
			cpu_irq_id <= sel_id;
			cpu_irq_prio <= sel_prio;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pending_out <= '0;
		else if (clk_en)
			pending_out <= pending_r;
	end

	a_fwd_gated: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !dist_en_r |=> !cpu_irq_valid)
		else $error("interrupt forwarded while distributor disabled");

	a_fwd_mask: assert property (@(posedge clk) disable iff (!rst_n)
		cpu_irq_valid |-> cpu_irq_prio < pmask_r || $changed(pmask_r))
		else $error("forwarded priority not below mask");

	a_en_clear: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_go && avs_address == `IRD_OFF_EN_CLR_HI && wmask[0]
		|=> !enable_r[32])
		else $error("enable not cleared");

	a_en_set: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_go && avs_address == `IRD_OFF_EN_SET_HI && wmask[5]
		|=> enable_r[37])
		else $error("enable not set");

	a_pend_set: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_go && avs_address == `IRD_OFF_PEND_SET_LO && wmask[31]
		|=> pending_r[31])
		else $error("pending not forced");

	a_pend_clr: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_go && avs_address == `IRD_OFF_PEND_CLR_HI && wmask[8]
		&& !line_event[40] |=> !pending_r[40])
		else $error("pending not cleared");

	a_low_fixed: assert property (@(posedge clk) disable iff (!rst_n)
		enable_r[28:0] == 29'h0)
		else $error("reserved enable bits set");

	a_line_pend: assert property (@(posedge clk) disable iff (!rst_n)
		line_event[40] |=> pending_r[40] ##1 (pending_out[40] || !$past(clk_en)))
		else $error("line event did not pend");

	a_sw_lock: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !sw_pend_set[3] && !$past(pending_r[3]) ##0 !pending_r[3] |=> !pending_r[3]
		|| $past(sw_pend_set[3]))
		else $error("software pend bit changed by bus");

	a_wait_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	a_act_copy: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_go && avs_address == `IRD_OFF_ACT_HI
		|=> active_r[63:32] == $past(active_in[63:32]))
		else $error("active flags moved by a bus write");

	a_pend_lock: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && wr_go && avs_address == `IRD_OFF_PEND_CLR_LO && wmask[3]
		&& pending_r[3] |=> pending_r[3])
		else $error("bus cleared a software pend bit");

	// clock enable low must hold the pending, enable and priority state
	a_frozen: assert property (@(posedge clk) disable iff (!rst_n)
		!clk_en |=> $stable(pending_r) && $stable(enable_r) && $stable(prio_r))
		else $error("state moved while clock enable low");

	a_type_lines: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && avs_read && bus_state_r == IRD_BUS_IDLE && avs_address == `IRD_OFF_TYPE
		|=> avs_readdata == 32'h0000_0001)
		else $error("type register reads wrong line count");

	// two equal candidates: the higher id must never win
	a_tie_low: assert property (@(posedge clk) disable iff (!rst_n)
		pending_r[34:33] == 2'b11 && enable_r[34:33] == 2'b11 && active_r[34:33] == 2'b00
		&& prio_r[33*4 +: 4] == prio_r[34*4 +: 4]
		|-> sel_id != 6'h22)
		else $error("equal priority picked the higher id");
endmodule

// ### src/ird_cfg.svh
/*
 * Register offsets, field positions, reset values and widths of the interrupt
 * distributor. Assumes inclusion by bare name from src/.
 */
`ifndef IRD_CFG_SVH
`define IRD_CFG_SVH

`define IRD_ADDR_W          12
`define IRD_NUM_IRQ         64
`define IRD_PRIO_W          4
`define IRD_OFF_CTRL        12'h000
`define IRD_OFF_TYPE        12'h004
`define IRD_OFF_EN_SET_LO   12'h100
`define IRD_OFF_EN_SET_HI   12'h104
`define IRD_OFF_EN_CLR_LO   12'h180
`define IRD_OFF_EN_CLR_HI   12'h184
`define IRD_OFF_PEND_SET_LO 12'h200
`define IRD_OFF_PEND_SET_HI 12'h204
`define IRD_OFF_PEND_CLR_LO 12'h280
`define IRD_OFF_PEND_CLR_HI 12'h284
`define IRD_OFF_ACT_LO      12'h300
`define IRD_OFF_ACT_HI      12'h304
`define IRD_OFF_PRIO_BASE   12'h400
`define IRD_OFF_PRIO_LAST   12'h43C
`define IRD_OFF_PMASK       12'h500
`define IRD_OFF_SELECT      12'h504
`define IRD_IMPL_LINES      5'b0_0001
`define IRD_LOW_WR_MASK     32'hE000_0000
`define IRD_HIGH_WR_MASK    32'hFFFF_FFFF
`define IRD_CTRL_EN_BIT     0
`define IRD_PMASK_RESET     4'hF
`define IRD_PRIO_RESET      4'h0

`endif

// ### src/ird_pkg.sv
/*
 * Types shared by the distributor files.
 * Assumes ird_cfg.svh is included before any user of the widths.
 */
`include "ird_cfg.svh"
package ird_pkg;
	typedef logic [`IRD_NUM_IRQ-1:0] ird_vec_t;
	typedef logic [`IRD_PRIO_W-1:0]  ird_prio_t;
	typedef logic [5:0]              ird_id_t;
	typedef enum logic [1:0]
	{
		IRD_BUS_IDLE = 2'b00,
		IRD_BUS_ACK  = 2'b01
	} ird_bus_state_t;
endpackage

// ### src/ird_edge_detect.sv
/*
 * Per-line event detector feeding the pending state.
 * Assumes source lines synchronous to clk, level high active.
 */
`timescale 1ns/1ns
`include "ird_cfg.svh"
module ird_edge_detect
	import ird_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst_n,
	input  wire logic     clk_en,
	input  wire ird_vec_t lines,
	output ird_vec_t      event_pulse
);
	ird_vec_t prev_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_r <= '0;
		else if (clk_en)
			prev_r <= lines;
	end

	// rising edge only, so a held line cannot re-pend after a software clear
	assign event_pulse = lines & ~prev_r & {`IRD_NUM_IRQ{clk_en}};
endmodule

// ### src/ird_select.sv
/*
 * Picks the most urgent enabled pending interrupt.
 * Assumes flat priority vector, 4 bits per interrupt.
 */
`timescale 1ns/1ns
`include "ird_cfg.svh"
module ird_select
	import ird_pkg::*;
(
	input  wire ird_vec_t                      cand,
	input  wire logic [`IRD_NUM_IRQ*4-1:0]     prio_flat,
	output logic                               found,
	output ird_id_t                            best_id,
	output ird_prio_t                          best_prio
);
	always_comb
	begin
		found = 1'b0;
		best_id = '0;
		best_prio = 4'hF;
		// strict less keeps the lowest id among equal priorities
		for (int i = 0; i < `IRD_NUM_IRQ; i++)
		begin
			if (cand[i] && (!found || prio_flat[i*4 +: 4] < best_prio))
			begin
				found = 1'b1;
				best_id = 6'(i);
				best_prio = prio_flat[i*4 +: 4];
			end
		end
	end
endmodule

// ### sim/ird_cpu_model.sv
/*
 * Behavioural CPU interface: takes the forwarded interrupt on an acknowledge
 * strobe and drops every active flag on an end strobe.
 * Assumes the bench drives both strobes on clk and feeds active_out back.
 */
`timescale 1ns/1ns
module ird_cpu_model
	import ird_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    rst_n,
	input  wire logic    irq_valid,
	input  wire ird_id_t irq_id,
	input  wire logic    ack_req,
	input  wire logic    end_req,
	output ird_vec_t     active_out
);
	// only a signalled interrupt can be taken
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			active_out <= '0;
		else if (end_req)
			active_out <= '0;
		else if (ack_req && irq_valid)
			active_out[irq_id] <= 1'b1;
	end
endmodule

// ### sim/ird_distributor_bench.sv
/*
 * Register and forwarding tests for the distributor over Avalon-MM.
 * Assumes the design and the CPU model compiled before this file.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) \
	begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module ird_distributor_bench
	import ird_pkg::*;
;
	logic            clk, rst_n, clk_en, avs_read, avs_write, avs_waitrequest;
	logic            cpu_irq_valid, ack_req, end_req;
	logic [11:0]     avs_address;
	logic [31:0]     avs_writedata, avs_readdata;
	logic [3:0]      avs_byteenable;
	ird_vec_t        irq_lines, sw_pend_set, active_in, pending_out;
	ird_id_t         cpu_irq_id;
	ird_prio_t       cpu_irq_prio;
	int              err_count, n_compared;

	ird_distributor ird_distributor_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.irq_lines(irq_lines), .sw_pend_set(sw_pend_set), .active_in(active_in),
		.cpu_irq_valid(cpu_irq_valid), .cpu_irq_id(cpu_irq_id),
		.cpu_irq_prio(cpu_irq_prio), .pending_out(pending_out));

	ird_cpu_model ird_cpu_model_i (.clk(clk), .rst_n(rst_n), .irq_valid(cpu_irq_valid),
		.irq_id(cpu_irq_id), .ack_req(ack_req), .end_req(end_req),
		.active_out(active_in));

	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// no local limit: only the watchdog ends a wait that never comes
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		`CHK($sformatf("reg %h", a), e, q)
	endtask

	// output follows state of the previous cycle, so a short settle suffices
	task automatic chk_cpu(input logic v, input ird_id_t id, input ird_prio_t p);
		repeat (3) @(posedge clk);
		`CHK("irq_valid", v, cpu_irq_valid)
		if (v)
		begin
			`CHK("irq_id", id, cpu_irq_id)
			`CHK("irq_prio", p, cpu_irq_prio)
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		#20000;
		err_count++;
		end_of_test;
	end

	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 12'h000;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		irq_lines = '0;
		sw_pend_set = '0;
		ack_req = 1'b0;
		end_req = 1'b0;
		err_count = 0;
		n_compared = 0;
		repeat (2) @(posedge clk);
		`CHK("prio_in_reset", 4'hF, cpu_irq_prio)
		`CHK("valid_in_reset", 1'b0, cpu_irq_valid)
		`CHK("wait_in_reset", 1'b1, avs_waitrequest)
		rst_n <= 1'b1;
		rd(12'h004, 32'h0000_0001);
		rd(12'h0F0, 32'h0000_0000);
		wr(12'h100, 32'hFFFF_FFFF);
		rd(12'h180, 32'hE000_0000);
		wr(12'h104, 32'hFFFF_FFFF);
		wr(12'h180, 32'h8000_FFFF);
		wr(12'h184, 32'h0000_0000);
		rd(12'h100, 32'h6000_0000);
		rd(12'h184, 32'hFFFF_FFFF);
		wr(12'h184, 32'h0000_0001);
		rd(12'h104, 32'hFFFF_FFFE);
		rd(12'h188, 32'h0000_0000);
		wr(12'h000, 32'h0000_0001);
		wr(12'h500, 32'h0000_0006);
		wr(12'h400, 32'hF000_0000);
		wr(12'h200, 32'hFFFF_FFFF);
		rd(12'h280, 32'hE000_0000);
		wr(12'h280, 32'h6000_0000);
		wr(12'h200, 32'h0000_0000);
		rd(12'h200, 32'h8000_0000);
		rd(12'h208, 32'h0000_0000);
		sw_pend_set <= 64'h0000_0000_0000_0008;
		@(posedge clk);
		sw_pend_set <= '0;
		wr(12'h280, 32'h8000_0008);
		rd(12'h200, 32'h0000_0008);
		irq_lines <= 64'h0000_0100_0000_0000;
		repeat (2) @(posedge clk);
		rd(12'h204, 32'h0000_0100);
		`CHK("pending_out", 64'h0000_0100_0000_0008, pending_out)
		wr(12'h284, 32'h0000_0100);
		rd(12'h284, 32'h0000_0000);
		wr(12'h204, 32'h0000_0006);
		wr(12'h420, 32'h0050_5000);
		rd(12'h420, 32'h0050_5000);
		chk_cpu(1'b1, 6'h21, 4'h5);
		wr(12'h420, 32'h0020_5000);
		chk_cpu(1'b1, 6'h22, 4'h2);
		wr(12'h500, 32'h0000_0002);
		chk_cpu(1'b0, 6'h00, 4'h0);
		wr(12'h500, 32'h0000_0003);
		chk_cpu(1'b1, 6'h22, 4'h2);
		ack_req <= 1'b1;
		@(posedge clk);
		ack_req <= 1'b0;
		wr(12'h304, 32'hFFFF_FFFF);
		rd(12'h304, 32'h0000_0004);
		rd(12'h300, 32'h0000_0000);
		wr(12'h500, 32'h0000_0006);
		chk_cpu(1'b1, 6'h21, 4'h5);
		wr(12'h000, 32'h0000_0000);
		chk_cpu(1'b0, 6'h00, 4'h0);
		// a rising line while frozen must be seen only once the enable returns
		clk_en <= 1'b0;
		irq_lines <= 64'h0000_0300_0000_0000;
		repeat (3) @(posedge clk);
		`CHK("frozen_pend", 64'h0000_0006_0000_0008, pending_out)
		clk_en <= 1'b1;
		rd(12'h204, 32'h0000_0206);
		end_req <= 1'b1;
		@(posedge clk);
		end_req <= 1'b0;
		rst_n <= 1'b0;
		irq_lines <= '0;
		repeat (2) @(posedge clk);
		`CHK("pend_in_reset", 64'h0000_0000_0000_0000, pending_out)
		rst_n <= 1'b1;
		rd(12'h204, 32'h0000_0000);
		rd(12'h104, 32'h0000_0000);
		end_of_test;
	end
endmodule
